/* File: hdl/dezs_pkg.sv */
package dezs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses on the 32-bit bus
   localparam logic [7:0] DEZS_ADDR_DRAM_CTL = 8'h18;
   localparam logic [7:0] DEZS_ADDR_ZERO_FILL_MODE_CTL = 8'h20;
   localparam logic [7:0] DEZS_ADDR_SCRUB_CTL = 8'h24;
   localparam logic [7:0] DEZS_ADDR_DUTY = 8'h34;

   // bit positions inside the 32-bit word
   localparam int DEZS_BIT_MEM_EN = 0;
   localparam int DEZS_BIT_ZERO_FILL_MODE = 28;
   localparam int DEZS_BIT_SCRUB_EN = 27;
   localparam int DEZS_BIT_SCRUB_ACT = 28;
   localparam int DEZS_DUTY_LSB = 24;
   localparam int DEZS_LANE_HI = 3;
   localparam int DEZS_LANE_LO = 0;

   // fields inside the duty timing byte
   localparam int DEZS_DUTY_RDIS = 7;
   localparam int DEZS_DUTY_TON_LSB = 3;
   localparam int DEZS_DUTY_TOFF_LSB = 0;
   localparam int DEZS_DUTY_FW = 3;
   localparam logic [7:0] DEZS_DUTY_FULL_FILL = 8'hB8;

   ////////////////////////////////////////////////////////////////////////////
   // memory side and timing
   localparam int DEZS_MEM_AW = 22;
   localparam logic [DEZS_MEM_AW-1:0] DEZS_MEM_LAST = '1;
   localparam logic [31:0] DEZS_ZERO_DATA = 32'h0000_0000;
   localparam logic [7:0] DEZS_ZERO_CHECK = 8'h00;
   localparam int DEZS_CLK_MHZ = 50;
   localparam int DEZS_FILL_MB_PER_S = 100;
   localparam int DEZS_BYTES_PER_WORD = 4;
   // longest allowed spacing of fill writes, rounded down, at least one
   localparam int DEZS_FILL_GAP_CYC_RAW =
      (DEZS_CLK_MHZ * DEZS_BYTES_PER_WORD) / DEZS_FILL_MB_PER_S;
   localparam int DEZS_FILL_GAP_CYC = (DEZS_FILL_GAP_CYC_RAW < 1) ? 1 : DEZS_FILL_GAP_CYC_RAW;

   ////////////////////////////////////////////////////////////////////////////
   // syndrome codes, index [bank][bit], bank 0 = A .. 3 = D
   localparam logic [7:0] DEZS_NO_ERR = 8'h00;
   localparam logic [7:0] DEZS_SYN_TBL [4][16] = '{
      '{8'h32, 8'h34, 8'h38, 8'hD3, 8'h54, 8'h58, 8'h98, 8'h94,
        8'h64, 8'h68, 8'h70, 8'hA7, 8'hA8, 8'hB0, 8'h31, 8'h29},
      '{8'hC8, 8'hD0, 8'hE0, 8'h4F, 8'h51, 8'h61, 8'h62, 8'h52,
        8'h91, 8'hA1, 8'hC1, 8'h9E, 8'hA2, 8'hC2, 8'hC4, 8'hA4},
      '{8'h23, 8'h43, 8'h83, 8'h3D, 8'h45, 8'h85, 8'h89, 8'h49,
        8'h46, 8'h86, 8'h07, 8'h7A, 8'h8A, 8'h0B, 8'h13, 8'h92},
      '{8'h8C, 8'h0D, 8'h0E, 8'hF4, 8'h15, 8'h16, 8'h26, 8'h25,
        8'h19, 8'h1A, 8'h1C, 8'hE9, 8'h2A, 8'h2C, 8'h4C, 8'h4A}};

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      DEZS_ST_IDLE = 2'b01,
      DEZS_ST_RUN = 2'b10
   } dezs_scrub_st_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [DEZS_MEM_AW-1:0] addr;
      logic [31:0] data;
      logic [7:0] check;
   } dezs_mem_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] syndrome;
      logic [1:0] addr_bank;
      logic multi_bit_error_flag;
   } dezs_syn_in_t;

   typedef struct packed {
      logic valid;
      logic no_error;
      logic data_err;
      logic check_err;
      logic uncorrectable;
      logic unknown;
      logic [1:0] bank;
      logic [3:0] bit_pos;
      logic [2:0] check_bit;
   } dezs_dec_t;

   typedef struct packed {
      dezs_scrub_st_t st;
      logic scrub_en;
      logic zero_fill_mode;
      logic mem_en;
      logic [7:0] duty;
      logic [DEZS_MEM_AW-1:0] addr;
      logic phase_on;
      logic [DEZS_DUTY_FW-1:0] phase_cnt;
      logic ack;
      logic [31:0] rdata;
      dezs_dec_t dec;
   } dezs_state_t;

   localparam dezs_state_t DEZS_STATE_RST = '{st: DEZS_ST_IDLE, default: '0};

endpackage

/* File: hdl/dezs_top.sv */
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
// Contract
// (RULE1) a full-rate zero fill clears memory at no less than 100 MB/s.
// (RULE2) software clears scrub enable, bit 27 at 0x24, before zero fill.
// (RULE3) software then waits for scrub active, bit 28, to read zero.
// (RULE4) software stops bus traffic to memory and clears memory enable bit 0.
// (RULE5) software sets zero fill mode, bit 28 at 0x20.
// (RULE6) software writes 0xB8 to duty timing: writes, full on, no off.
// (RULE7) setting scrub enable starts the pass and raises scrub active.
// (RULE8) clearing scrub enable mid pass ends after the pass, no repeat.
// (RULE9) scrub active drops when the pass completes; software waits for it.
// (RULE10) software clears zero fill mode before normal setup and memory enable.
// (RULE11) software may choose a slower scrub rate to limit memory power.
// (RULE12) syndrome zero reports no error.
// (RULE13) any nonzero syndrome is an error located by the fixed table.
// (RULE14) error bank comes from address bits 3 and 2, A to D.
// (RULE15) bank D data bit syndromes follow the fixed table.
// (RULE16) bank C data bit syndromes follow the fixed table.
// (RULE17) bank B data bit syndromes follow the fixed table.
// (RULE18) bank A data bit syndromes follow the fixed table.
// (RULE19) a check bit error gives a one-hot syndrome of that bit.
// (RULE20) a multi-bit error syndrome is not decoded.
// (RULE21) each fill write stores zero data with matching check bits.
module dezs_top
   import dezs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output dezs_mem_req_t mem_o,
   input wire logic mem_ready_i,
   output logic memory_enable_o,
   output logic zero_fill_mode_o,
   output logic scrub_active_o,
   input wire dezs_syn_in_t syn_i,
   output dezs_dec_t dec_o
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // read mux for the register words
   function automatic logic [31:0] dezs_read_word(logic [7:0] a, dezs_state_t s);
      logic [31:0] w;
      w = '0;
      if (a == DEZS_ADDR_DRAM_CTL) begin
         w[DEZS_BIT_MEM_EN] = s.mem_en;
      end else if (a == DEZS_ADDR_ZERO_FILL_MODE_CTL) begin
         w[DEZS_BIT_ZERO_FILL_MODE] = s.zero_fill_mode;
      end else if (a == DEZS_ADDR_SCRUB_CTL) begin
         w[DEZS_BIT_SCRUB_EN] = s.scrub_en;
         w[DEZS_BIT_SCRUB_ACT] = (s.st == DEZS_ST_RUN);
      end else if (a == DEZS_ADDR_DUTY) begin
         w[DEZS_DUTY_LSB +: 8] = s.duty;
      end
      return w;
   endfunction

   // syndrome decode, a pure function: table walk plus one-hot check bit test
   function automatic dezs_dec_t dezs_decode(dezs_syn_in_t s);
      dezs_dec_t d;
      logic hit;
      logic [1:0] tbank;
      logic [3:0] tbit;
      d = '0;
      hit = 1'b0;
      tbank = '0;
      tbit = '0;
      d.valid = s.valid;
      d.bank = s.addr_bank; // RULE14
      for (int b = 0; b < 4; b++) begin
         for (int k = 0; k < 16; k++) begin
            if (DEZS_SYN_TBL[b][k] == s.syndrome) begin
               hit = 1'b1;
               tbank = 2'(b);
               tbit = 4'(k);
            end
         end
      end
      if (s.multi_bit_error_flag) begin
         // position is meaningless here, leave fields clear
         d.uncorrectable = 1'b1; // RULE20
      end else if (s.syndrome == DEZS_NO_ERR) begin
         d.no_error = 1'b1; // RULE12
      end else if ($onehot(s.syndrome)) begin
         d.check_err = 1'b1; // RULE19
         for (int i = 0; i < 8; i++) begin
            if (s.syndrome[i]) begin
               d.check_bit = 3'(i);
            end
         end
      end else if (hit && tbank == s.addr_bank) begin
         // RULE13 RULE15 RULE16 RULE17 RULE18
         d.data_err = 1'b1;
         d.bit_pos = tbit;
      end else begin
         // code outside the table or bank mismatch: error, position unknown
         d.unknown = 1'b1; // RULE13
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   dezs_state_t r_reg;
   dezs_state_t r_next;
   logic bus_req;
   logic bus_take;
   logic mem_take;
   logic [DEZS_DUTY_FW-1:0] ton;
   logic [DEZS_DUTY_FW-1:0] toff;

   assign bus_req = avs_read_i | avs_write_i;
   // one wait cycle on every access keeps read data registered
   assign avs_waitrequest_o = bus_req & ~r_reg.ack;
   assign bus_take = bus_req & r_reg.ack;
   assign ton = r_reg.duty[DEZS_DUTY_TON_LSB +: DEZS_DUTY_FW];
   assign toff = r_reg.duty[DEZS_DUTY_TOFF_LSB +: DEZS_DUTY_FW];
   assign mem_take = mem_o.req & mem_ready_i;

   // outputs straight from the state register
   assign avs_readdata_o = r_reg.rdata;
   assign memory_enable_o = r_reg.mem_en;
   assign zero_fill_mode_o = r_reg.zero_fill_mode;
   assign scrub_active_o = (r_reg.st == DEZS_ST_RUN);
   assign dec_o = r_reg.dec;

   // memory request; writes only when read is disabled in fill mode
   always_comb begin
      mem_o.req = (r_reg.st == DEZS_ST_RUN) & r_reg.phase_on;
      mem_o.we = r_reg.zero_fill_mode & r_reg.duty[DEZS_DUTY_RDIS];
      mem_o.addr = r_reg.addr;
      mem_o.data = DEZS_ZERO_DATA; // RULE21
      mem_o.check = DEZS_ZERO_CHECK; // RULE21
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_next = r_reg;

      // bus slave: first cycle loads read data, second completes
      r_next.ack = bus_req & ~r_reg.ack;
      if (bus_req && !r_reg.ack) begin
         r_next.rdata = dezs_read_word(avs_address_i, r_reg);
      end
      if (avs_write_i && bus_take) begin
         if (avs_address_i == DEZS_ADDR_DRAM_CTL) begin
            if (avs_byteenable_i[DEZS_LANE_LO]) begin
               r_next.mem_en = avs_writedata_i[DEZS_BIT_MEM_EN];
            end
         end else if (avs_address_i == DEZS_ADDR_ZERO_FILL_MODE_CTL) begin
            if (avs_byteenable_i[DEZS_LANE_HI]) begin
               r_next.zero_fill_mode = avs_writedata_i[DEZS_BIT_ZERO_FILL_MODE];
            end
         end else if (avs_address_i == DEZS_ADDR_SCRUB_CTL) begin
            if (avs_byteenable_i[DEZS_LANE_HI]) begin
               r_next.scrub_en = avs_writedata_i[DEZS_BIT_SCRUB_EN];
            end
         end else if (avs_address_i == DEZS_ADDR_DUTY) begin
            if (avs_byteenable_i[DEZS_LANE_HI]) begin
               r_next.duty = avs_writedata_i[DEZS_DUTY_LSB +: 8];
            end
         end
      end

      // scrubber pass engine
      case (r_reg.st)
         DEZS_ST_IDLE: begin
            if (r_reg.scrub_en) begin
               r_next.st = DEZS_ST_RUN; // RULE7
               r_next.addr = '0;
               r_next.phase_on = 1'b1;
               r_next.phase_cnt = '0;
            end
         end
         DEZS_ST_RUN: begin
            if (r_reg.phase_on) begin
               if (mem_take) begin
                  if (r_reg.addr == DEZS_MEM_LAST) begin
                     r_next.addr = '0;
                     // enable sampled only at the pass boundary
                     if (!r_reg.scrub_en) begin
                        r_next.st = DEZS_ST_IDLE; // RULE8 RULE9
                     end
                  end else begin
                     r_next.addr = r_reg.addr + 1'b1;
                  end
                  // on time counts accepted cycles so a stall never cuts a request
                  if (r_reg.phase_cnt == ton) begin
                     r_next.phase_cnt = '0;
                     r_next.phase_on = (toff == '0); // RULE1
                  end else begin
                     r_next.phase_cnt = r_reg.phase_cnt + 1'b1;
                  end
               end
            end else begin
               if (r_reg.phase_cnt + 1'b1 == toff) begin
                  r_next.phase_cnt = '0;
                  r_next.phase_on = 1'b1;
               end else begin
                  r_next.phase_cnt = r_reg.phase_cnt + 1'b1;
               end
            end
         end
         default: begin
            r_next.st = DEZS_ST_IDLE;
         end
      endcase

      // syndrome fields held until the next valid sample; the valid flag lasts one cycle
      if (syn_i.valid) begin
         r_next.dec = dezs_decode(syn_i);
      end else begin
         r_next.dec.valid = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= DEZS_STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking dezs_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic pass_end;
   assign pass_end = mem_take & (r_reg.addr == DEZS_MEM_LAST);

   // full-rate fill issues a write every cycle while memory is ready
   chk_fill_full_rate: assert property ( // RULE1
      (r_reg.st == DEZS_ST_RUN && r_reg.duty == DEZS_DUTY_FULL_FILL && r_reg.zero_fill_mode
       && mem_ready_i) |-> (mem_o.req && mem_o.we) ##1 (mem_o.req || !scrub_active_o))
      else $error("fill rate below one write per cycle");

   chk_start_raises_active: assert property ( // RULE7
      (r_reg.st == DEZS_ST_IDLE && r_reg.scrub_en) |=> scrub_active_o && mem_o.addr == '0)
      else $error("scrub active did not rise after enable");

   chk_pass_stops: assert property ( // RULE8
      (pass_end && !r_reg.scrub_en) |=> !scrub_active_o ##1 !scrub_active_o)
      else $error("pass repeated after enable cleared");

   chk_pass_repeats: assert property ( // RULE9
      (pass_end && r_reg.scrub_en) |=> scrub_active_o && mem_o.addr == '0)
      else $error("pass did not restart with enable set");

   chk_active_holds: assert property ( // RULE9
      (scrub_active_o && !pass_end) |=> scrub_active_o)
      else $error("scrub active dropped before pass end");

   chk_fill_zero_word: assert property ( // RULE21
      (mem_o.req && mem_o.we) |-> mem_o.data == DEZS_ZERO_DATA
         && mem_o.check == DEZS_ZERO_CHECK && r_reg.zero_fill_mode)
      else $error("fill write carries nonzero word");

   chk_syn_zero: assert property ( // RULE12
      (syn_i.valid && !syn_i.multi_bit_error_flag && syn_i.syndrome == DEZS_NO_ERR)
      |=> dec_o.valid && dec_o.no_error && !dec_o.data_err && !dec_o.check_err)
      else $error("zero syndrome not reported as clean");

   chk_syn_nonzero: assert property ( // RULE13
      (syn_i.valid && !syn_i.multi_bit_error_flag && syn_i.syndrome != DEZS_NO_ERR)
      |=> !dec_o.no_error && (dec_o.data_err || dec_o.check_err || dec_o.unknown))
      else $error("nonzero syndrome not reported as error");

   chk_bank_from_addr: assert property ( // RULE14
      syn_i.valid |=> dec_o.bank == $past(syn_i.addr_bank))
      else $error("error bank not taken from address bits");

   chk_bank_d_bit0: assert property ( // RULE15
      (syn_i.valid && !syn_i.multi_bit_error_flag && syn_i.syndrome == 8'h8C && syn_i.addr_bank == 2'h3)
      |=> dec_o.data_err && dec_o.bit_pos == 4'h0)
      else $error("bank d bit 0 decoded wrong");

   chk_bank_c_bit15: assert property ( // RULE16
      (syn_i.valid && !syn_i.multi_bit_error_flag && syn_i.syndrome == 8'h92 && syn_i.addr_bank == 2'h2)
      |=> dec_o.data_err && dec_o.bit_pos == 4'hF)
      else $error("bank c bit 15 decoded wrong");

   chk_bank_b_bit1: assert property ( // RULE17
      (syn_i.valid && !syn_i.multi_bit_error_flag && syn_i.syndrome == 8'hD0 && syn_i.addr_bank == 2'h1)
      |=> dec_o.data_err && dec_o.bit_pos == 4'h1)
      else $error("bank b bit 1 decoded wrong");

   chk_bank_a_bit15: assert property ( // RULE18
      (syn_i.valid && !syn_i.multi_bit_error_flag && syn_i.syndrome == 8'h29 && syn_i.addr_bank == 2'h0)
      |=> dec_o.data_err && dec_o.bit_pos == 4'hF)
      else $error("bank a bit 15 decoded wrong");

   chk_check_onehot: assert property ( // RULE19
      (syn_i.valid && !syn_i.multi_bit_error_flag && $onehot(syn_i.syndrome))
      |=> dec_o.check_err && (8'h01 << dec_o.check_bit) == $past(syn_i.syndrome))
      else $error("check bit error decoded wrong");

   chk_mbe_undecoded: assert property ( // RULE20
      (syn_i.valid && syn_i.multi_bit_error_flag) |=> dec_o.uncorrectable && !dec_o.data_err
         && !dec_o.check_err && !dec_o.no_error)
      else $error("multi-bit error decoded to a position");

   chk_bus_one_wait: assert property (
      (bus_req && !r_reg.ack) |-> avs_waitrequest_o ##1 (!bus_req || !avs_waitrequest_o))
      else $error("bus access not answered after one wait");

   cov_fill_pass_done: cover property (
      r_reg.zero_fill_mode && pass_end && !r_reg.scrub_en ##1 !scrub_active_o);
   cov_data_error: cover property (syn_i.valid ##1 dec_o.data_err);
   cov_check_error: cover property (syn_i.valid ##1 dec_o.check_err);
   cov_reg_write: cover property (avs_write_i && !avs_waitrequest_o);

endmodule

/* File: test/dezs_mem_model.sv */
`timescale 1ns/1ns
module dezs_mem_model
   import dezs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire dezs_mem_req_t mem_i,
   input wire logic stall_i,
   output logic mem_ready_o,
   output int count_o,
   output int err_o
);
   // the array takes a word on any cycle it is not told to stall
   assign mem_ready_o = ~stall_i;

   ////////////////////////////////////////////////////////////////////////////
   // every accepted fill word must be the next address, zero data, zero check
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= 0;
         err_o <= 0;
      end else if (mem_i.req && mem_ready_o) begin
         count_o <= count_o + 1;
         if (mem_i.addr !== count_o[DEZS_MEM_AW-1:0] || mem_i.we !== 1'b1 ||
             mem_i.data !== DEZS_ZERO_DATA || mem_i.check !== DEZS_ZERO_CHECK) begin
            err_o <= err_o + 1;
         end
      end
   end
endmodule

/* File: test/dezs_top_bench.sv */
`timescale 1ns/1ns
module dezs_top_bench
   import dezs_pkg::*;
;
   logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, stall = 0, rnd_stall = 0;
   logic [7:0] avs_address_i = '0;
   logic [31:0] avs_writedata_i = '0, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic avs_waitrequest_o, mem_ready_i, memory_enable_o, zero_fill_mode_o, scrub_active_o;
   dezs_mem_req_t mem_o;
   dezs_syn_in_t syn_i = '0;
   dezs_dec_t dec_o;
   int fail_count = 0, comparisons = 0, cyc = 0, cnt, err, c0;
   // every mapped register, for the reset value sweep
   logic [7:0] reg_addr [4] = '{DEZS_ADDR_DRAM_CTL, DEZS_ADDR_ZERO_FILL_MODE_CTL, DEZS_ADDR_SCRUB_CTL,
                                DEZS_ADDR_DUTY};

   dezs_top dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .mem_o(mem_o), .mem_ready_i(mem_ready_i),
      .memory_enable_o(memory_enable_o), .zero_fill_mode_o(zero_fill_mode_o),
      .scrub_active_o(scrub_active_o), .syn_i(syn_i), .dec_o(dec_o));
   dezs_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o), .stall_i(stall),
      .mem_ready_o(mem_ready_i), .count_o(cnt), .err_o(err));

   ////////////////////////////////////////////////////////////////////////////
   // 50 MHz clock, random memory stalls, and a hang limit
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      stall <= rnd_stall ? 1'($urandom % 2) : 1'b0;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one Avalon access, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] rd);
      @(posedge clk_i);
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      // waitrequest and read data are both taken at the completing edge itself
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   // decode model: table lookup in the addressed bank, one-hot check bits
   task automatic syn(input logic [7:0] s, input logic [1:0] b, input logic m);
      int n, k;
      n = -1;
      k = -1;
      for (int i = 0; i < 16; i++) if (DEZS_SYN_TBL[b][i] == s) n = i;
      for (int i = 0; i < 8; i++) if (s == (8'h01 << i)) k = i;
      @(posedge clk_i);
      syn_i <= '{valid: 1'b1, syndrome: s, addr_bank: b, multi_bit_error_flag: m};
      @(posedge clk_i);
      syn_i.valid <= 1'b0;
      #1;
      check("dec valid", dec_o.valid, 1);
      check("no error", dec_o.no_error, s == 0 && !m);
      check("uncorrectable", dec_o.uncorrectable, m);
      check("data err", dec_o.data_err, !m && n >= 0);
      check("check err", dec_o.check_err, !m && k >= 0);
      check("unknown", dec_o.unknown, !m && s != 0 && n < 0 && k < 0);
      if (!m && n >= 0) begin
         check("bank", dec_o.bank, b);
         check("bit pos", dec_o.bit_pos, n);
      end
      if (!m && k >= 0) check("check bit", dec_o.check_bit, k);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'hd8cf));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, byte lanes, unmapped place
      foreach (reg_addr[i]) begin
         bus(0, reg_addr[i], '0, 4'hF, q);
         check("reset value", q, 0);
      end
      bus(1, 8'h28, $urandom, 4'hF, q);
      bus(0, 8'h28, '0, 4'hF, q);
      check("unmapped read", q, 0);
      bus(1, DEZS_ADDR_DRAM_CTL, 32'h0000_0001, 4'h8, q);
      bus(0, DEZS_ADDR_DRAM_CTL, '0, 4'hF, q);
      check("lane off", q, 0);
      bus(1, DEZS_ADDR_DRAM_CTL, 32'h0000_0001, 4'hF, q);
      bus(0, DEZS_ADDR_DRAM_CTL, '0, 4'hF, q);
      check("mem enable reg", q, 32'h0000_0001);
      check("mem enable pin", memory_enable_o, 1);
      bus(1, DEZS_ADDR_SCRUB_CTL, 32'h1000_0000, 4'hF, q);
      bus(0, DEZS_ADDR_SCRUB_CTL, '0, 4'hF, q);
      check("active read only", q, 0);
      $display("test registers done");
      // zero fill sequence, software steps in order
      rnd_stall <= 1'b1;
      bus(1, DEZS_ADDR_SCRUB_CTL, '0, 4'hF, q);
      do bus(0, DEZS_ADDR_SCRUB_CTL, '0, 4'hF, q); while (q[28] !== 1'b0);
      bus(1, DEZS_ADDR_DRAM_CTL, '0, 4'hF, q);
      bus(1, DEZS_ADDR_ZERO_FILL_MODE_CTL, 32'h1000_0000, 4'hF, q);
      bus(1, DEZS_ADDR_DUTY, 32'hB800_0000, 4'hF, q);
      check("fill pin", zero_fill_mode_o, 1);
      check("mem enable off", memory_enable_o, 0);
      bus(0, DEZS_ADDR_DUTY, '0, 4'hF, q);
      check("duty", q, 32'hB800_0000);
      check("no fill before enable", cnt, 0);
      bus(1, DEZS_ADDR_SCRUB_CTL, 32'h0800_0000, 4'hF, q);
      do bus(0, DEZS_ADDR_SCRUB_CTL, '0, 4'hF, q); while (q[28] !== 1'b1);
      repeat (200) @(posedge clk_i);
      rnd_stall <= 1'b0;
      repeat (2) @(posedge clk_i);
      c0 = cnt;
      repeat (200) @(posedge clk_i);
      // 100 MB/s at 50 MHz is one word every two cycles
      check("fill rate", (cnt - c0) >= 200 / DEZS_FILL_GAP_CYC, 1);
      bus(1, DEZS_ADDR_SCRUB_CTL, '0, 4'hF, q);
      repeat (50) @(posedge clk_i);
      bus(0, DEZS_ADDR_SCRUB_CTL, '0, 4'hF, q);
      check("pass continues", q, 32'h1000_0000);
      check("active pin", scrub_active_o, 1);
      check("fill words", err, 0);
      // slower duty: on 1 gives two writes, then off 2 idle cycles, so half rate
      bus(1, DEZS_ADDR_DUTY, 32'h8A00_0000, 4'hF, q);
      repeat (20) @(posedge clk_i);
      c0 = cnt;
      repeat (200) @(posedge clk_i);
      check("slow rate", (cnt - c0) >= 98 && (cnt - c0) <= 102, 1);
      check("slow fill words", err, 0);
      // second reset in mid pass
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check("active after reset", scrub_active_o, 0);
      check("req after reset", mem_o.req, 0);
      // scrubber idle: fill mode off first, only then memory handed back
      bus(1, DEZS_ADDR_ZERO_FILL_MODE_CTL, '0, 4'hF, q);
      bus(1, DEZS_ADDR_DRAM_CTL, 32'h0000_0001, 4'hF, q);
      #1;
      check("fill mode cleared", zero_fill_mode_o, 0);
      check("memory back on", memory_enable_o, 1);
      $display("test zero fill done");
      // syndromes: whole table, check bits, zero, wrong bank, multi-bit
      for (int b = 0; b < 4; b++) begin
         for (int i = 0; i < 16; i++) syn(DEZS_SYN_TBL[b][i], 2'(b), 1'b0);
      end
      for (int k = 0; k < 8; k++) syn(8'h01 << k, 2'($urandom), 1'b0);
      syn(DEZS_NO_ERR, 2'($urandom), 1'b0);
      syn(DEZS_SYN_TBL[0][0], 2'd1, 1'b0);
      syn(8'h8C, 2'd3, 1'b1);
      repeat (20) syn(8'($urandom), 2'($urandom), 1'($urandom % 4 == 0));
      @(posedge clk_i);
      #1;
      check("valid one cycle", dec_o.valid, 0);
      $display("test syndrome done");
      end_sim();
   end
endmodule
